// File: pkg/synth_latch_params.svh
/*
  Constants of the synthesizer latch programming logic: latch address codes,
  field positions of the three 24-bit latches and timing figures.
  Assumes it is included by its bare name after the package.
*/
`ifndef SYNTH_LATCH_PARAMS_SVH
`define SYNTH_LATCH_PARAMS_SVH

`define WORD_BITS 24
`define ADDR_MSB 1
`define ADDR_LSB 0
`define ADDR_CTRL 2'h0
`define ADDR_REF 2'h1
`define ADDR_FDBK 2'h2
`define ADDR_TEST 2'h3

`define CTRL_CORE_LSB 2
`define CTRL_CORE_MSB 3
`define CTRL_CNT_RST 4
`define CTRL_MUX_LSB 5
`define CTRL_MUX_MSB 7
`define CTRL_POLARITY 8
`define CTRL_TRISTATE 9
`define CTRL_GAIN 10
`define CTRL_MUTE 11
`define CTRL_LEVEL_LSB 12
`define CTRL_LEVEL_MSB 13
`define CTRL_CUR_LO_LSB 14
`define CTRL_CUR_LO_MSB 16
`define CTRL_CUR_HI_LSB 17
`define CTRL_CUR_HI_MSB 19
`define CTRL_PD_ARM 20
`define CTRL_PD_MODE 21
`define CTRL_PRESC_LSB 22
`define CTRL_PRESC_MSB 23

`define FDBK_SWALLOW_LSB 2
`define FDBK_SWALLOW_MSB 6
`define FDBK_MAIN_LSB 8
`define FDBK_MAIN_MSB 20
`define FDBK_GAIN 21
`define FDBK_HALVING 22
`define FDBK_HALVED_SEL 23

`define REF_RATIO_LSB 2
`define REF_RATIO_MSB 15
`define REF_PRECISION 18
`define REF_TEST_FLAG 19
`define REF_BAND_LSB 20
`define REF_BAND_MSB 21

`define LATCH_RESET 24'h000000
`define LOCK_CYCLES_FINE 3'h5
`define LOCK_CYCLES_COARSE 3'h3
`define LOCK_ERR_NS 15
`define SYS_CLK_NS 50

`endif

// File: pkg/synth_latch_pkg.sv
/*
  Types of the synthesizer latch programming logic.
  Assumes nothing of its surroundings.
*/
package synth_latch_pkg;
  typedef logic [23:0] latch_word_t;
  typedef enum logic [1:0] {PD_RUN, PD_WAIT_FIRST, PD_WAIT_SECOND, PD_DOWN} pd_state_e;
endpackage

// File: verilog/serial_word_shifter.sv
/*
  Serial input register of the three-wire interface, clocked by the host's
  serial clock. Assumes the host holds the serial clock still while the latch
  strobe is high, so the word is stable when the system domain samples it.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_word_shifter #(
  parameter int WIDTH = 24
) (
  input wire logic serial_clk_in,
  input wire logic serial_data_in,
  output logic [WIDTH-1:0] word_out
);
  logic [WIDTH-1:0] shift_reg;
  logic [WIDTH-1:0] shift_next;

  always_comb begin
    shift_next = {shift_reg[WIDTH-2:0], serial_data_in};
  end

  // no reset: the link clock may be stopped, and the word is pure data
  always_ff @(posedge serial_clk_in) begin
    shift_reg <= shift_next;
  end

  assign word_out = shift_reg;
endmodule
`default_nettype wire

// File: verilog/synth_latch_programming.sv
/*
  Latch programming logic of an integer-N synthesizer: latch transfer,
  power-down control, reference and feedback counters, phase detector
  steering, lock detection and band select clock.
  Assumes serial data arrives on its own clock, and that strobe, chip enable,
  reference and prescaler pins are asynchronous to clk_sys_in.
*/
`timescale 1ns/1ps
`default_nettype none
`include "synth_latch_params.svh"
module synth_latch_programming import synth_latch_pkg::*; #(
  parameter int LOCK_ERR_NS = `LOCK_ERR_NS,
  parameter int SYS_CLK_NS = `SYS_CLK_NS
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic serial_clk_in,
  input wire logic serial_data_in,
  input wire logic latch_strobe_in,
  input wire logic chip_enable_in,
  input wire logic ref_clk_in,
  input wire logic prescaler_pulse_in,
  output logic powered_down_out,
  output logic ref_buffer_enable_out,
  output logic rf_output_enable_out,
  output logic [1:0] rf_output_level_out,
  output logic [1:0] core_current_level_out,
  output logic pump_up_out,
  output logic pump_down_out,
  output logic pump_tristate_out,
  output logic [2:0] pump_current_code_out,
  output logic modulus_ctrl_out,
  output logic [5:0] prescaler_modulus_out,
  output logic output_halving_out,
  output logic prescaler_from_halved_out,
  output logic band_select_tick_out,
  output logic lock_detect_out,
  output logic multiplexed_status_pin_out
);
  // a longest time rounds down, but never below one cycle
  localparam int LOCK_WIN_RAW = LOCK_ERR_NS / SYS_CLK_NS;
  localparam int LOCK_WIN = (LOCK_WIN_RAW < 1) ? 1 : LOCK_WIN_RAW;

  function automatic logic [5:0] modulus_of(input logic [1:0] code);
    if (code == 2'h0) begin
      modulus_of = 6'h08;
    end else if (code == 2'h1) begin
      modulus_of = 6'h10;
    end else begin
      modulus_of = 6'h20;
    end
  endfunction

  latch_word_t serial_word;
  serial_word_shifter #(.WIDTH(`WORD_BITS)) u_shifter (
    .serial_clk_in(serial_clk_in),
    .serial_data_in(serial_data_in),
    .word_out(serial_word)
  );

  // pin synchronisers; stage one feeds stage two only
  logic [1:0] strobe_sync_reg, ce_sync_reg, ref_sync_reg, pre_sync_reg;
  logic strobe_last_reg, ref_last_reg, pre_last_reg;
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      strobe_sync_reg <= 2'h0;
      ce_sync_reg <= 2'h0;
      ref_sync_reg <= 2'h0;
      pre_sync_reg <= 2'h0;
      strobe_last_reg <= 1'b0;
      ref_last_reg <= 1'b0;
      pre_last_reg <= 1'b0;
    end else begin
      strobe_sync_reg <= {strobe_sync_reg[0], latch_strobe_in};
      ce_sync_reg <= {ce_sync_reg[0], chip_enable_in};
      ref_sync_reg <= {ref_sync_reg[0], ref_clk_in};
      pre_sync_reg <= {pre_sync_reg[0], prescaler_pulse_in};
      strobe_last_reg <= strobe_sync_reg[1];
      ref_last_reg <= ref_sync_reg[1];
      pre_last_reg <= pre_sync_reg[1];
    end
  end

  logic strobe_rise, ref_edge, pre_edge;
  logic [1:0] word_addr;
  assign strobe_rise = strobe_sync_reg[1] & ~strobe_last_reg;
  assign ref_edge = ref_sync_reg[1] & ~ref_last_reg;
  assign pre_edge = pre_sync_reg[1] & ~pre_last_reg;
  assign word_addr = serial_word[`ADDR_MSB:`ADDR_LSB];

  // latches; the serial word is quasi-static while the strobe is high
  latch_word_t ctrl_reg, ctrl_next, fdbk_reg, fdbk_next, ref_reg, ref_next;
  logic gain_reg, gain_next, ctrl_write;
  always_comb begin
    ctrl_next = ctrl_reg;
    fdbk_next = fdbk_reg;
    ref_next = ref_reg;
    gain_next = gain_reg;
    ctrl_write = 1'b0;
    if (strobe_rise && word_addr == `ADDR_CTRL) begin
      ctrl_next = serial_word;
      ctrl_write = 1'b1;
      gain_next = serial_word[`CTRL_GAIN];
    end else if (strobe_rise && word_addr == `ADDR_FDBK) begin
      fdbk_next = serial_word;
      gain_next = serial_word[`FDBK_GAIN];
    end else if (strobe_rise && word_addr == `ADDR_REF) begin
      ref_next = serial_word;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ctrl_reg <= `LATCH_RESET;
      fdbk_reg <= `LATCH_RESET;
      ref_reg <= `LATCH_RESET;
      gain_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      fdbk_reg <= fdbk_next;
      ref_reg <= ref_next;
      gain_reg <= gain_next;
    end
  end

  // power-down sequencing
  pd_state_e pd_state_reg, pd_state_next;
  logic r_tick_reg, powered_down;
  always_comb begin
    pd_state_next = pd_state_reg;
    case (pd_state_reg)
      PD_RUN, PD_WAIT_FIRST, PD_WAIT_SECOND: begin
        if (ctrl_write && !serial_word[`CTRL_PD_ARM]) begin
          pd_state_next = PD_RUN;
        end else if (ctrl_write && !serial_word[`CTRL_PD_MODE]) begin
          pd_state_next = PD_DOWN;
        end else if (ctrl_write) begin
          pd_state_next = PD_WAIT_FIRST;
        end else if (pd_state_reg == PD_WAIT_FIRST && r_tick_reg) begin
          pd_state_next = PD_WAIT_SECOND;
        end else if (pd_state_reg == PD_WAIT_SECOND && r_tick_reg) begin
          pd_state_next = PD_DOWN;
        end
      end
      default: begin
        if (ctrl_write && !serial_word[`CTRL_PD_ARM]) begin
          pd_state_next = PD_RUN;
        end
      end
    endcase
  end
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      pd_state_reg <= PD_RUN;
    end else begin
      pd_state_reg <= pd_state_next;
    end
  end
  assign powered_down = (pd_state_reg == PD_DOWN) | ~ce_sync_reg[1];

  // reference, feedback and band select counters
  logic [13:0] ref_cnt_reg, ref_cnt_next, ref_ratio;
  logic [12:0] main_cnt_reg, main_cnt_next, main_load;
  logic [4:0] swallow_cnt_reg, swallow_cnt_next, swallow_load;
  logic [2:0] band_cnt_reg, band_cnt_next, band_last;
  logic r_tick_next, n_tick_reg, n_tick_next, band_tick_reg, band_tick_next, hold;
  assign ref_ratio = ref_reg[`REF_RATIO_MSB:`REF_RATIO_LSB];
  assign swallow_load = fdbk_reg[`FDBK_SWALLOW_MSB:`FDBK_SWALLOW_LSB];
  assign main_load = fdbk_reg[`FDBK_MAIN_MSB:`FDBK_MAIN_LSB];
  // divide by one, two, four or eight
  assign band_last = 3'((4'h1 << ref_reg[`REF_BAND_MSB:`REF_BAND_LSB]) - 4'h1);
  assign hold = powered_down | ctrl_reg[`CTRL_CNT_RST];
  always_comb begin
    ref_cnt_next = ref_cnt_reg;
    main_cnt_next = main_cnt_reg;
    swallow_cnt_next = swallow_cnt_reg;
    band_cnt_next = band_cnt_reg;
    r_tick_next = 1'b0;
    n_tick_next = 1'b0;
    band_tick_next = 1'b0;
    if (hold) begin
      ref_cnt_next = ref_ratio;
      main_cnt_next = main_load;
      swallow_cnt_next = swallow_load;
      band_cnt_next = 3'h0;
    end else begin
      if (ref_edge) begin
        if (ref_cnt_reg <= 14'h0001) begin
          ref_cnt_next = ref_ratio;
          r_tick_next = 1'b1;
        end else begin
          ref_cnt_next = ref_cnt_reg - 14'h0001;
        end
      end
      // swallow pulses at modulus plus one, rest at modulus
      if (pre_edge) begin
        if (swallow_cnt_reg != 5'h00) begin
          swallow_cnt_next = swallow_cnt_reg - 5'h01;
        end
        if (main_cnt_reg <= 13'h0001) begin
          main_cnt_next = main_load;
          swallow_cnt_next = swallow_load;
          n_tick_next = 1'b1;
        end else begin
          main_cnt_next = main_cnt_reg - 13'h0001;
        end
      end
      if (r_tick_reg) begin
        if (band_cnt_reg >= band_last) begin
          band_cnt_next = 3'h0;
          band_tick_next = 1'b1;
        end else begin
          band_cnt_next = band_cnt_reg + 3'h1;
        end
      end
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ref_cnt_reg <= 14'h0000;
      main_cnt_reg <= 13'h0000;
      swallow_cnt_reg <= 5'h00;
      band_cnt_reg <= 3'h0;
      r_tick_reg <= 1'b0;
      n_tick_reg <= 1'b0;
      band_tick_reg <= 1'b0;
    end else begin
      ref_cnt_reg <= ref_cnt_next;
      main_cnt_reg <= main_cnt_next;
      swallow_cnt_reg <= swallow_cnt_next;
      band_cnt_reg <= band_cnt_next;
      r_tick_reg <= r_tick_next;
      n_tick_reg <= n_tick_next;
      band_tick_reg <= band_tick_next;
    end
  end

  // phase detector, lock detection and status pin
  logic up_reg, up_next, dn_reg, dn_next, locked_reg, locked_next, status_reg, status_next, good;
  logic [3:0] n_age_reg, n_age_next;
  logic [2:0] lock_cnt_reg, lock_cnt_next, lock_need;
  logic [2:0] mux_code;
  assign lock_need = ref_reg[`REF_PRECISION] ? `LOCK_CYCLES_FINE : `LOCK_CYCLES_COARSE;
  assign mux_code = ctrl_reg[`CTRL_MUX_MSB:`CTRL_MUX_LSB];
  // phase error is judged only at the reference tick, a feedback tick up to one window early counts
  assign good = n_tick_reg | (n_age_reg < 4'(LOCK_WIN));
  always_comb begin
    up_next = up_reg | r_tick_reg;
    dn_next = dn_reg | n_tick_reg;
    n_age_next = n_tick_reg ? 4'h0 : ((n_age_reg == 4'hF) ? n_age_reg : n_age_reg + 4'h1);
    lock_cnt_next = lock_cnt_reg;
    locked_next = locked_reg;
    if (up_next && dn_next) begin
      up_next = 1'b0;
      dn_next = 1'b0;
    end
    if (r_tick_reg && good) begin
      lock_cnt_next = (lock_cnt_reg >= lock_need) ? lock_need : lock_cnt_reg + 3'h1;
      locked_next = locked_reg | (lock_cnt_next == lock_need);
    end else if (r_tick_reg) begin
      lock_cnt_next = 3'h0;
      locked_next = 1'b0;
    end
    if (hold) begin
      up_next = 1'b0;
      dn_next = 1'b0;
      n_age_next = 4'hF;
      lock_cnt_next = 3'h0;
      locked_next = 1'b0;
    end
    if (mux_code == 3'h1) begin
      status_next = locked_next;
    end else if (mux_code == 3'h2) begin
      status_next = n_tick_next;
    end else if (mux_code == 3'h4) begin
      status_next = r_tick_next;
    end else begin
      status_next = 1'b0;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      up_reg <= 1'b0;
      dn_reg <= 1'b0;
      n_age_reg <= 4'hF;
      lock_cnt_reg <= 3'h0;
      locked_reg <= 1'b0;
      status_reg <= 1'b0;
    end else begin
      up_reg <= up_next;
      dn_reg <= dn_next;
      n_age_reg <= n_age_next;
      lock_cnt_reg <= lock_cnt_next;
      locked_reg <= locked_next;
      status_reg <= status_next;
    end
  end

  // pump floats when tristated or down
  assign pump_tristate_out = powered_down | ctrl_reg[`CTRL_TRISTATE];
  assign pump_up_out = ~pump_tristate_out & (ctrl_reg[`CTRL_POLARITY] ? up_reg : dn_reg);
  assign pump_down_out = ~pump_tristate_out & (ctrl_reg[`CTRL_POLARITY] ? dn_reg : up_reg);
  assign pump_current_code_out = gain_reg ? ctrl_reg[`CTRL_CUR_HI_MSB:`CTRL_CUR_HI_LSB]
                                          : ctrl_reg[`CTRL_CUR_LO_MSB:`CTRL_CUR_LO_LSB];
  // RF off while down or muted unlocked
  assign rf_output_enable_out = ~powered_down & (~ctrl_reg[`CTRL_MUTE] | locked_reg);
  assign ref_buffer_enable_out = ~powered_down;
  assign powered_down_out = powered_down;
  assign rf_output_level_out = ctrl_reg[`CTRL_LEVEL_MSB:`CTRL_LEVEL_LSB];
  assign core_current_level_out = ctrl_reg[`CTRL_CORE_MSB:`CTRL_CORE_LSB];
  assign modulus_ctrl_out = (swallow_cnt_reg != 5'h00);
  assign prescaler_modulus_out = modulus_of(ctrl_reg[`CTRL_PRESC_MSB:`CTRL_PRESC_LSB]);
  assign output_halving_out = fdbk_reg[`FDBK_HALVING];
  assign prescaler_from_halved_out = fdbk_reg[`FDBK_HALVED_SEL];
  assign band_select_tick_out = band_tick_reg;
  assign lock_detect_out = locked_reg;
  assign multiplexed_status_pin_out = status_reg;

  a_async_pd: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    ctrl_write && serial_word[`CTRL_PD_ARM] && !serial_word[`CTRL_PD_MODE] |=> pd_state_reg == PD_DOWN)
    else $error("async power-down not immediate");
  a_sync_pd_wait: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    ctrl_write && serial_word[`CTRL_PD_ARM] && serial_word[`CTRL_PD_MODE] && pd_state_reg != PD_DOWN
    |=> pd_state_reg == PD_WAIT_FIRST ##1 pd_state_reg != PD_DOWN)
    else $error("sync power-down entered early");
  a_sync_pd_second: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    pd_state_reg == PD_WAIT_SECOND && r_tick_reg && !ctrl_write |=> pd_state_reg == PD_DOWN)
    else $error("sync power-down missed second tick");
  a_ce_override: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    !ce_sync_reg[1] |-> powered_down_out && !rf_output_enable_out && !ref_buffer_enable_out)
    else $error("chip enable low did not disable");
  a_pd_counters: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    powered_down |-> pump_tristate_out ##1 (ref_cnt_reg == $past(ref_ratio) && main_cnt_reg == $past(main_load)
      && swallow_cnt_reg == $past(swallow_load) && !locked_reg && !up_reg && !dn_reg))
    else $error("power-down did not load counters");
  a_pd_loading: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    powered_down && strobe_rise && word_addr == `ADDR_CTRL |=> ctrl_reg == $past(serial_word))
    else $error("latch not loaded while powered down");
  a_gain_latest: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    strobe_rise && word_addr == `ADDR_FDBK |=> gain_reg == $past(serial_word[`FDBK_GAIN]))
    else $error("gain does not follow feedback write");
  a_mute_lock: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    ctrl_reg[`CTRL_MUTE] && !locked_reg |-> !rf_output_enable_out)
    else $error("RF enabled before lock");
  a_counter_reset: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    ctrl_reg[`CTRL_CNT_RST] [*2] |-> !r_tick_reg && !n_tick_reg)
    else $error("counters ran during counter reset");
  a_lock_count: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    $rose(locked_reg) |-> lock_cnt_reg == lock_need && $past(r_tick_reg))
    else $error("lock declared at wrong count");
  a_latch_hold: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    !strobe_rise || word_addr == `ADDR_TEST |=> $stable(ctrl_reg) && $stable(fdbk_reg) && $stable(ref_reg))
    else $error("latch changed without addressed strobe");
endmodule
`default_nettype wire

// File: test/synth_host_model.sv
/*
  Host side of the three-wire link: shifts 24-bit words and raises the strobe.
  Assumes one caller at a time and that the serial clock may stop between words.
*/
`timescale 1ns/1ps
`default_nettype none
module synth_host_model import synth_latch_pkg::*; (
  output logic serial_clk_out,
  output logic serial_data_out,
  output logic latch_strobe_out
);
  initial begin
    serial_clk_out = 1'h0;
    serial_data_out = 1'h0;
    latch_strobe_out = 1'h0;
  end

  task automatic write_word(input latch_word_t w);
    latch_word_t v;
    v = w;
    if (v[1:0] == 2'h2) v[7] = 1'h0;
    if (v[1:0] == 2'h1) v[23:22] = 2'h0;
    for (int i = 23; i >= 0; i--) begin
      serial_data_out = v[i];
      #3 serial_clk_out = 1'h1;
      #3 serial_clk_out = 1'h0;
    end
    // data is not held after the frame, so show the inverse
    serial_data_out = ~v[0];
    #20 latch_strobe_out = 1'h1;
    // clock stays still while the strobe is high and well after its rise
    #250 latch_strobe_out = 1'h0;
    #300;
  endtask
endmodule
`default_nettype wire

// File: test/synth_latch_programming_bench.sv
/*
  Self-checking bench of the synthesizer latch programming logic.
  Assumes the host model drives the serial link and the bench all other pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "synth_latch_params.svh"
module synth_latch_programming_bench import synth_latch_pkg::*;;
  logic clk_sys_in = 1'h0;
  logic srst_in = 1'h1;
  logic chip_enable_in = 1'h1;
  logic ref_clk_in = 1'h0;
  logic prescaler_pulse_in = 1'h0;
  wire logic sclk, sdata, strobe, pd, rbe, rfe, tri_s, half, hsel, lock, mux, pu, pdn, mctl, band;
  wire logic [1:0] lvl, core;
  wire logic [2:0] cur;
  wire logic [5:0] modv;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;
  int bands = 0;
  int n0 = 0;
  latch_word_t c, f, t;
  logic g;

  always #25 clk_sys_in = ~clk_sys_in;

  synth_host_model host_u (.serial_clk_out(sclk), .serial_data_out(sdata), .latch_strobe_out(strobe));

  synth_latch_programming dut_u (
    .clk_sys_in, .srst_in, .serial_clk_in(sclk), .serial_data_in(sdata), .latch_strobe_in(strobe),
    .chip_enable_in, .ref_clk_in, .prescaler_pulse_in, .powered_down_out(pd), .ref_buffer_enable_out(rbe),
    .rf_output_enable_out(rfe), .rf_output_level_out(lvl), .core_current_level_out(core), .pump_up_out(pu),
    .pump_down_out(pdn), .pump_tristate_out(tri_s), .pump_current_code_out(cur), .modulus_ctrl_out(mctl),
    .prescaler_modulus_out(modv), .output_halving_out(half), .prescaler_from_halved_out(hsel),
    .band_select_tick_out(band), .lock_detect_out(lock), .multiplexed_status_pin_out(mux)
  );

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function automatic logic [2:0] exp_cur(input latch_word_t w, input logic gain);
    return gain ? w[`CTRL_CUR_HI_MSB:`CTRL_CUR_HI_LSB] : w[`CTRL_CUR_LO_MSB:`CTRL_CUR_LO_LSB];
  endfunction

  function automatic logic [5:0] exp_mod(input logic [1:0] p);
    return p == 2'h0 ? 6'h08 : (p == 2'h1 ? 6'h10 : 6'h20);
  endfunction

  task automatic wr(input latch_word_t w);
    host_u.write_word(w);
    @(negedge clk_sys_in);
  endtask

  // each period: three prescaler edges, the last one together with a reference edge
  task automatic pulses(input int n);
    repeat (n) begin
      for (int k = 0; k < 3; k++) begin
        @(posedge clk_sys_in);
        prescaler_pulse_in <= 1'h1;
        ref_clk_in <= (k == 2);
        repeat (2) @(posedge clk_sys_in);
        prescaler_pulse_in <= 1'h0;
        ref_clk_in <= 1'h0;
        @(posedge clk_sys_in);
      end
    end
    repeat (4) @(negedge clk_sys_in);
  endtask

  always @(posedge clk_sys_in) begin
    if (band === 1'h1) bands++;
    cycles++;
    if (cycles == 30000) begin
      fails++;
      end_of_test;
    end
  end

  initial begin
    void'($urandom(32'hD1DAA981));
    repeat (20) @(posedge clk_sys_in);
    srst_in <= 1'h0;
    repeat (4) @(negedge clk_sys_in);
    check("powered_down", pd, 1'h0);
    wr({8'h00, 14'h0001, `ADDR_REF});
    wr(24'h000000);
    wr({3'h0, 13'h0003, 1'h0, 5'h00, `ADDR_FDBK});
    for (int i = 0; i < 8; i++) begin
      c = 24'($urandom);
      c[1:0] = `ADDR_CTRL;
      c[23:22] = i[1:0];
      c[21:20] = 2'h0;
      c[11] = 1'h0;
      c[9] = 1'h0;
      c[4] = 1'h0;
      wr(c);
      check("modulus", modv, exp_mod(c[23:22]));
      check("current", cur, exp_cur(c, c[10]));
      check("level", lvl, c[13:12]);
      check("core", core, c[3:2]);
      f = 24'($urandom);
      f[1:0] = `ADDR_FDBK;
      // main count bit two set, never below four
      f[10] = 1'h1;
      wr(f);
      g = f[21];
      check("current", cur, exp_cur(c, g));
      check("halving", half, f[22]);
      check("halved_sel", hsel, f[23]);
      t = 24'($urandom);
      t[1:0] = `ADDR_TEST;
      wr(t);
      check("current", cur, exp_cur(c, g));
      check("halving", half, f[22]);
    end
    c[21:20] = 2'h1;
    wr(c);
    check("powered_down", pd, 1'h1);
    check("ref_buffer", rbe, 1'h0);
    check("rf_enable", rfe, 1'h0);
    check("pump_float", tri_s, 1'h1);
    c[10] = ~c[10];
    wr(c);
    check("current", cur, exp_cur(c, c[10]));
    c[21:20] = 2'h0;
    wr(c);
    check("powered_down", pd, 1'h0);
    c[21:20] = 2'h3;
    wr(c);
    check("powered_down", pd, 1'h0);
    pulses(1);
    check("powered_down", pd, 1'h0);
    pulses(1);
    check("powered_down", pd, 1'h1);
    c[21:20] = 2'h0;
    wr(c);
    @(posedge clk_sys_in);
    chip_enable_in <= 1'h0;
    repeat (4) @(negedge clk_sys_in);
    check("powered_down", pd, 1'h1);
    @(posedge clk_sys_in);
    chip_enable_in <= 1'h1;
    repeat (4) @(negedge clk_sys_in);
    check("powered_down", pd, 1'h0);
    c[9] = 1'h1;
    wr(c);
    check("pump_float", tri_s, 1'h1);
    check("pump_up", pu, 1'h0);
    check("pump_down", pdn, 1'h0);
    c[9] = 1'h0;
    wr(c);
    check("pump_float", tri_s, 1'h0);
    wr({5'h00, 1'h1, 2'h0, 14'h0001, `ADDR_REF});
    wr({3'h0, 13'h0003, 1'h0, 5'h01, `ADDR_FDBK});
    c = 24'h000000;
    c[11] = 1'h1;
    c[7:5] = 3'h1;
    c[4] = 1'h1;
    wr(c);
    c[4] = 1'h0;
    wr(c);
    pulses(3);
    check("lock", lock, 1'h0);
    check("rf_enable", rfe, 1'h0);
    pulses(5);
    check("lock", lock, 1'h1);
    check("rf_enable", rfe, 1'h1);
    check("status_pin", mux, 1'h1);
    c[4] = 1'h1;
    wr(c);
    check("lock", lock, 1'h0);
    check("modulus_ctrl", mctl, 1'h1);
    wr({2'h0, 2'h1, 4'h0, 14'h0001, `ADDR_REF});
    c[4] = 1'h0;
    wr(c);
    n0 = bands;
    pulses(4);
    check("lock", lock, 1'h1);
    check("band_ticks", 24'(bands - n0), 24'h000002);
    // a lone reference edge leaves the up request pending
    @(posedge clk_sys_in);
    ref_clk_in <= 1'h1;
    repeat (2) @(posedge clk_sys_in);
    ref_clk_in <= 1'h0;
    repeat (4) @(negedge clk_sys_in);
    check("lock", lock, 1'h0);
    check("pump_up", pu, 1'h0);
    check("pump_down", pdn, 1'h1);
    c[8] = 1'h1;
    wr(c);
    check("pump_up", pu, 1'h1);
    check("pump_down", pdn, 1'h0);
    end_of_test;
  end
endmodule
`default_nettype wire
